// File: can_ctl_pkg.sv
// Constants, field layout and mode codes for the CAN mode and buffer control block.
// Assumes a 100 MHz register clock and word-aligned AHB-Lite register access.
// Overview of operation
// - Mode request field decodes normal, disable, loopback, listen-only, config, listen-all.
// - Reported mode field is read-only and uses the request encoding.
// - Listen-only is passive: no error flags, no acknowledge, error counters off.
// - Listen-only releases the transmit pin to port use; receive stays input.
// - Listen-all ignores errors, accepts all, copies partial message on error.
// - Loopback ties internal transmit to internal receive; both pins go to port use.
// - Stop-in-idle bit: one halts the module in CPU idle, zero keeps running.
// - Abort-all bit set by software; hardware clears it once all aborts finish.
// - Capture-enable bit makes each received message fire a timestamp capture event.
// - Window-select bit maps filter registers when one, buffer registers when zero.
// - Five-bit data bit count for identifier-plus-data filtering; codes above 10001 invalid.
// - Read-only filter hit field names matching filter zero to fifteen.
// - Interrupt code reports none, error, wake-up, overflow or FIFO almost full.
// - Buffer interrupts report the buffer index zero to fifteen as code.
// - Buffer count code selects 4,6,8,12,16,24 or 32 buffers; 111 reserved.
// - Writable five-bit field selects the buffer where the receive FIFO begins.
// - Read-only write pointer gives the buffer index the FIFO fills next.
// - Read-only read pointer gives the buffer index software reads next.
// - Reported mode changes only when acceptable, normally after eleven recessive bits.
// - Configuration registers writable only in configuration mode; no entry during transmit.
package can_ctl_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL      = 3'h0,
    MODE_DISABLE     = 3'h1,
    MODE_LOOPBACK    = 3'h2,
    MODE_LISTEN_ONLY = 3'h3,
    MODE_CONFIG      = 3'h4,
    MODE_LISTEN_ALL  = 3'h7
  } mode_e;

  // Register byte offsets
  localparam logic [11:0] OFS_MODE_CONTROL     = 12'h000;
  localparam logic [11:0] OFS_FILTER_BIT_COUNT = 12'h004;
  localparam logic [11:0] OFS_INTERRUPT_CODE   = 12'h008;
  localparam logic [11:0] OFS_FIFO_SETUP       = 12'h00C;
  localparam logic [11:0] OFS_FIFO_POINTERS    = 12'h010;

  // mode_control fields
  localparam int POS_STOP_IN_IDLE   = 13;
  localparam int POS_ABORT_ALL_TX   = 12;
  localparam int POS_MODE_REQUEST   = 8;
  localparam int POS_MODE_REPORT    = 5;
  localparam int POS_RX_CAPTURE_EN  = 3;
  localparam int POS_WINDOW_SELECT  = 0;

  // interrupt_code fields
  localparam int POS_FILTER_HIT     = 8;
  localparam int POS_ICODE          = 0;

  // fifo_setup and fifo_pointers fields
  localparam int POS_DMA_BUF_COUNT  = 13;
  localparam int POS_FIFO_START     = 0;
  localparam int POS_FIFO_WRITE_PTR = 8;
  localparam int POS_FIFO_READ_PTR  = 0;

  // Reset values
  localparam mode_e       RST_MODE          = MODE_CONFIG;
  localparam logic [4:0]  RST_FILTER_COUNT  = 5'h00;
  localparam logic [2:0]  RST_DMA_BUF_COUNT = 3'h0;
  localparam logic [4:0]  RST_FIFO_START    = 5'h00;

  // Field limits and codes
  localparam logic [4:0]  FILTER_COUNT_MAX  = 5'h11;
  localparam logic [2:0]  DMA_BUF_RESERVED  = 3'h7;
  localparam logic [6:0]  ICODE_NONE        = 7'h40;
  localparam logic [6:0]  ICODE_ERROR       = 7'h41;
  localparam logic [6:0]  ICODE_WAKE        = 7'h42;
  localparam logic [6:0]  ICODE_RX_OVERFLOW = 7'h43;
  localparam logic [6:0]  ICODE_FIFO_AFULL  = 7'h44;

  // Bus idle timing
  localparam int IDLE_RECESSIVE_BITS = 11;
  localparam int CLK_HZ              = 100_000_000;
  localparam int BIT_RATE_HZ         = 1_000_000;
  localparam int BIT_CYCLES          = CLK_HZ / BIT_RATE_HZ;

endpackage : can_ctl_pkg

// File: bus_idle_detect.sv
// Bus idle detector: counts recessive bit times on the receive line.
// Assumes rx_in is already synchronised to mclk_in.
`timescale 1ns/100ps
module bus_idle_detect #(
  parameter int BIT_CYCLES = can_ctl_pkg::BIT_CYCLES,
  parameter int IDLE_BITS  = can_ctl_pkg::IDLE_RECESSIVE_BITS
) (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic rx_in,
  output logic      idle_out
);
  import can_ctl_pkg::*;

  logic [15:0] div_q;
  logic        tick_q;
  logic [4:0]  run_q;

  // Bit-time enable pulse
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else if (div_q == 16'(BIT_CYCLES - 1))
    begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // Consecutive recessive bits, restarted by any dominant level
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      run_q <= 5'h00;
    else if (!rx_in)
      run_q <= 5'h00;
    else if (tick_q && run_q != 5'(IDLE_BITS))
      run_q <= run_q + 5'h01;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      idle_out <= 1'b0;
    else
      idle_out <= rx_in && (run_q == 5'(IDLE_BITS));
  end

endmodule : bus_idle_detect

// File: can_mode_and_buffer_control.sv
// Mode, abort, capture, window, filter count, interrupt code and FIFO pointer control.
// Assumes an AHB-Lite master on mclk_in and a protocol engine on the same clock.
`timescale 1ns/100ps
module can_mode_and_buffer_control #(
  parameter int BIT_CYCLES = can_ctl_pkg::BIT_CYCLES
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic [11:0] haddr_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  // CAN pins
  input  wire logic        can_rx_pin_in,
  output logic             can_tx_pin_out,
  output logic             can_tx_pin_oe_out,
  output logic             tx_pin_port_io_out,
  output logic             rx_pin_port_io_out,
  // Protocol engine side
  input  wire logic        engine_tx_in,
  input  wire logic        tx_busy_in,
  input  wire logic        all_aborted_in,
  input  wire logic        rx_done_in,
  input  wire logic [3:0]  filter_hit_in,
  input  wire logic        err_pend_in,
  input  wire logic        wake_pend_in,
  input  wire logic        rx_ovf_pend_in,
  input  wire logic        fifo_afull_pend_in,
  input  wire logic [15:0] buf_pend_in,
  input  wire logic        fifo_fill_in,
  input  wire logic        fifo_read_in,
  input  wire logic        cpu_idle_in,
  output logic             engine_rx_out,
  output logic             online_out,
  output logic             passive_out,
  output logic             err_count_enable_out,
  output logic             err_count_clear_out,
  output logic             accept_all_out,
  output logic             copy_on_error_out,
  output logic             abort_all_tx_out,
  output logic             module_halt_out,
  output logic             capture_event_out,
  output logic             window_select_out,
  output logic [4:0]       filter_data_bit_count_out,
  output logic [2:0]       dma_buffer_count_out,
  output logic [4:0]       fifo_start_buffer_out
);
  import can_ctl_pkg::*;

  // Number of buffers for a buffer-count code
  function automatic logic [5:0] buf_total(input logic [2:0] code);
    logic [5:0] n;
    n = 6'h04;
    unique case (code)
      3'h0: n = 6'h04;
      3'h1: n = 6'h06;
      3'h2: n = 6'h08;
      3'h3: n = 6'h0C;
      3'h4: n = 6'h10;
      3'h5: n = 6'h18;
      3'h6: n = 6'h20;
      default: n = 6'h20;
    endcase
    return n;
  endfunction : buf_total

  // Next FIFO index, wrapping from the last buffer back to the start
  function automatic logic [5:0] ptr_next(input logic [5:0] p, input logic [2:0] code,
                                          input logic [4:0] start);
    logic [5:0] last;
    last = buf_total(code) - 6'h01;
    if (p >= last)
      return {1'b0, start};
    return p + 6'h01;
  endfunction : ptr_next

  function automatic logic is_mode(input logic [2:0] code);
    return code != 3'h5 && code != 3'h6;
  endfunction : is_mode

  mode_e       mode_request_q;
  mode_e       mode_report_q;
  logic        stop_in_idle_q;
  logic        abort_all_tx_q;
  logic        rx_capture_enable_q;
  logic        window_select_q;
  logic [4:0]  filter_data_bit_count_q;
  logic [2:0]  dma_buffer_count_q;
  logic [4:0]  fifo_start_buffer_q;
  logic [5:0]  fifo_write_pointer_q;
  logic [5:0]  fifo_read_pointer_q;
  logic [4:0]  filter_hit_number_q;
  logic [6:0]  interrupt_code_q;
  logic        rx_meta_q;
  logic        rx_sync_q;
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        rd_pend_q;
  logic [11:0] rd_addr_q;
  logic        bus_idle;
  logic        internal_rx;
  logic        in_config;
  logic        mode_ok;
  logic        take;
  logic [31:0] rd_mux;
  logic        wr_ctl;
  logic        wr_filt;
  logic        wr_fifo;

  assign in_config = (mode_report_q == MODE_CONFIG);
  assign take      = hsel_in && htrans_in[1] && hready_in;
  assign wr_ctl    = wr_pend_q && (wr_addr_q == OFS_MODE_CONTROL);
  assign wr_filt   = wr_pend_q && (wr_addr_q == OFS_FILTER_BIT_COUNT) && in_config;
  assign wr_fifo   = wr_pend_q && (wr_addr_q == OFS_FIFO_SETUP) && in_config;

  // Receive pin synchroniser
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end
    else
    begin
      rx_meta_q <= can_rx_pin_in;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Loopback routes the engine transmit straight back to its receive
  assign internal_rx = (mode_report_q == MODE_LOOPBACK) ? engine_tx_in : rx_sync_q;

  bus_idle_detect #(
    .BIT_CYCLES (BIT_CYCLES),
    .IDLE_BITS  (IDLE_RECESSIVE_BITS)
  ) u_idle (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .rx_in      (internal_rx),
    .idle_out   (bus_idle)
  );

  // AHB-Lite address phase capture; reads take one wait state
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_pend_q     <= 1'b0;
      wr_addr_q     <= 12'h000;
      rd_pend_q     <= 1'b0;
      rd_addr_q     <= 12'h000;
      hreadyout_out <= 1'b1;
      hrdata_out    <= 32'h0000_0000;
      hresp_out     <= 1'b0;
    end
    else
    begin
      hresp_out <= 1'b0;
      wr_pend_q <= take && hwrite_in;
      if (take)
      begin
        wr_addr_q <= {haddr_in[11:2], 2'b00};
        rd_addr_q <= {haddr_in[11:2], 2'b00};
      end
      rd_pend_q <= take && !hwrite_in;
      if (take && !hwrite_in)
        hreadyout_out <= 1'b0;
      else if (rd_pend_q)
      begin
        hreadyout_out <= 1'b1;
        hrdata_out    <= rd_mux;
      end
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (rd_addr_q)
      OFS_MODE_CONTROL:
      begin
        rd_mux[POS_STOP_IN_IDLE]                  = stop_in_idle_q;
        rd_mux[POS_ABORT_ALL_TX]                  = abort_all_tx_q;
        rd_mux[POS_MODE_REQUEST +: 3]             = mode_request_q;
        rd_mux[POS_MODE_REPORT +: 3]              = mode_report_q;
        rd_mux[POS_RX_CAPTURE_EN]                 = rx_capture_enable_q;
        rd_mux[POS_WINDOW_SELECT]                 = window_select_q;
      end
      OFS_FILTER_BIT_COUNT: rd_mux[4:0]           = filter_data_bit_count_q;
      OFS_INTERRUPT_CODE:
      begin
        rd_mux[POS_FILTER_HIT +: 5]               = filter_hit_number_q;
        rd_mux[POS_ICODE +: 7]                    = interrupt_code_q;
      end
      OFS_FIFO_SETUP:
      begin
        rd_mux[POS_DMA_BUF_COUNT +: 3]            = dma_buffer_count_q;
        rd_mux[POS_FIFO_START +: 5]               = fifo_start_buffer_q;
      end
      OFS_FIFO_POINTERS:
      begin
        rd_mux[POS_FIFO_WRITE_PTR +: 6]           = fifo_write_pointer_q;
        rd_mux[POS_FIFO_READ_PTR +: 6]            = fifo_read_pointer_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Mode request; reserved codes leave the request unchanged
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      mode_request_q <= RST_MODE;
    else if (wr_ctl && is_mode(hwdata_in[POS_MODE_REQUEST +: 3]))
      mode_request_q <= mode_e'(hwdata_in[POS_MODE_REQUEST +: 3]);
  end

  // Changes out of config or disable happen at once, none into config while tx_busy_in; changes from on-line modes wait for an idle bus
  always_comb
  begin
    mode_ok = bus_idle || mode_report_q == MODE_CONFIG || mode_report_q == MODE_DISABLE;
    if (mode_request_q == MODE_CONFIG && tx_busy_in)
      mode_ok = 1'b0;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      mode_report_q <= RST_MODE;
    else if (mode_request_q != mode_report_q && mode_ok)
      mode_report_q <= mode_request_q;
  end

  // Control bits locked outside configuration mode
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      stop_in_idle_q      <= 1'b0;
      rx_capture_enable_q <= 1'b0;
    end
    else if (wr_ctl && in_config)
    begin
      stop_in_idle_q      <= hwdata_in[POS_STOP_IN_IDLE];
      rx_capture_enable_q <= hwdata_in[POS_RX_CAPTURE_EN];
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      window_select_q <= 1'b0;
    else if (wr_ctl)
      window_select_q <= hwdata_in[POS_WINDOW_SELECT];
  end

  // Abort-all: software sets, hardware clears, a set in the same cycle wins
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      abort_all_tx_q <= 1'b0;
    else if (wr_ctl && hwdata_in[POS_ABORT_ALL_TX])
      abort_all_tx_q <= 1'b1;
    else if (all_aborted_in)
      abort_all_tx_q <= 1'b0;
  end

  // Filter data bit count; invalid codes are not stored
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      filter_data_bit_count_q <= RST_FILTER_COUNT;
    else if (wr_filt && hwdata_in[4:0] <= FILTER_COUNT_MAX)
      filter_data_bit_count_q <= hwdata_in[4:0];
  end

  // FIFO area setup; a reserved buffer count keeps the old count
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      dma_buffer_count_q  <= RST_DMA_BUF_COUNT;
      fifo_start_buffer_q <= RST_FIFO_START;
    end
    else if (wr_fifo)
    begin
      if (hwdata_in[POS_DMA_BUF_COUNT +: 3] != DMA_BUF_RESERVED)
        dma_buffer_count_q <= hwdata_in[POS_DMA_BUF_COUNT +: 3];
      fifo_start_buffer_q <= hwdata_in[POS_FIFO_START +: 5];
    end
  end

  // FIFO pointers restart at the FIFO start while configuring
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      fifo_write_pointer_q <= 6'h00;
      fifo_read_pointer_q  <= 6'h00;
    end
    else if (in_config)
    begin
      fifo_write_pointer_q <= {1'b0, fifo_start_buffer_q};
      fifo_read_pointer_q  <= {1'b0, fifo_start_buffer_q};
    end
    else
    begin
      if (fifo_fill_in)
        fifo_write_pointer_q <= ptr_next(fifo_write_pointer_q, dma_buffer_count_q,
                                         fifo_start_buffer_q);
      if (fifo_read_in)
        fifo_read_pointer_q  <= ptr_next(fifo_read_pointer_q, dma_buffer_count_q,
                                         fifo_start_buffer_q);
    end
  end

  // Filter hit latched per received message
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      filter_hit_number_q <= 5'h00;
    else if (rx_done_in)
      filter_hit_number_q <= {1'b0, filter_hit_in};
  end

  // Interrupt code: module events first, then lowest pending buffer
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      interrupt_code_q <= ICODE_NONE;
    else if (err_pend_in)
      interrupt_code_q <= ICODE_ERROR;
    else if (wake_pend_in)
      interrupt_code_q <= ICODE_WAKE;
    else if (rx_ovf_pend_in)
      interrupt_code_q <= ICODE_RX_OVERFLOW;
    else if (fifo_afull_pend_in)
      interrupt_code_q <= ICODE_FIFO_AFULL;
    else
    begin
      interrupt_code_q <= ICODE_NONE;
      for (int i = 15; i >= 0; i--)
        if (buf_pend_in[i])
          interrupt_code_q <= 7'(i);
    end
  end

  // Mode-derived controls and pin ownership
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      online_out           <= 1'b0;
      passive_out          <= 1'b0;
      err_count_enable_out <= 1'b0;
      err_count_clear_out  <= 1'b1;
      accept_all_out       <= 1'b0;
      copy_on_error_out    <= 1'b0;
      tx_pin_port_io_out   <= 1'b1;
      rx_pin_port_io_out   <= 1'b1;
      can_tx_pin_out       <= 1'b1;
      can_tx_pin_oe_out    <= 1'b0;
      engine_rx_out        <= 1'b1;
    end
    else
    begin
      online_out           <= !(mode_report_q inside {MODE_CONFIG, MODE_DISABLE});
      passive_out          <= mode_report_q == MODE_LISTEN_ONLY;
      err_count_enable_out <= mode_report_q inside {MODE_NORMAL, MODE_LOOPBACK};
      err_count_clear_out  <= in_config;
      accept_all_out       <= mode_report_q == MODE_LISTEN_ALL;
      copy_on_error_out    <= mode_report_q == MODE_LISTEN_ALL;
      tx_pin_port_io_out   <= !(mode_report_q inside {MODE_NORMAL, MODE_LISTEN_ALL});
      rx_pin_port_io_out   <= !(mode_report_q inside {MODE_NORMAL, MODE_LISTEN_ONLY,
                                                      MODE_LISTEN_ALL});
      can_tx_pin_oe_out    <= mode_report_q inside {MODE_NORMAL, MODE_LISTEN_ALL};
      can_tx_pin_out       <= (mode_report_q inside {MODE_NORMAL, MODE_LISTEN_ALL})
                              ? engine_tx_in : 1'b1;
      engine_rx_out        <= internal_rx;
    end
  end

  // Halt, abort, capture and configuration outputs
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      module_halt_out           <= 1'b0;
      capture_event_out         <= 1'b0;
      abort_all_tx_out          <= 1'b0;
      window_select_out         <= 1'b0;
      filter_data_bit_count_out <= RST_FILTER_COUNT;
      dma_buffer_count_out      <= RST_DMA_BUF_COUNT;
      fifo_start_buffer_out     <= RST_FIFO_START;
    end
    else
    begin
      module_halt_out           <= stop_in_idle_q && cpu_idle_in;
      capture_event_out         <= rx_capture_enable_q && rx_done_in;
      abort_all_tx_out          <= abort_all_tx_q;
      window_select_out         <= window_select_q;
      filter_data_bit_count_out <= filter_data_bit_count_q;
      dma_buffer_count_out      <= dma_buffer_count_q;
      fifo_start_buffer_out     <= fifo_start_buffer_q;
    end
  end

endmodule : can_mode_and_buffer_control

// File: can_ctl_asserts.sv
// Port checker for the CAN mode and buffer control block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
module can_ctl_asserts (
  input wire logic       mclk_in,
  input wire logic       reset_n_in,
  input wire logic       hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic       hready_in,
  input wire logic       hwrite_in,
  input wire logic       hreadyout_out,
  input wire logic       passive_out,
  input wire logic       tx_pin_port_io_out,
  input wire logic       rx_pin_port_io_out,
  input wire logic       err_count_enable_out,
  input wire logic       err_count_clear_out,
  input wire logic       accept_all_out,
  input wire logic       copy_on_error_out,
  input wire logic       engine_rx_out,
  input wire logic       engine_tx_in,
  input wire logic       capture_event_out,
  input wire logic       rx_done_in,
  input wire logic       module_halt_out,
  input wire logic       cpu_idle_in,
  input wire logic       abort_all_tx_out,
  input wire logic       all_aborted_in
);
  logic wr_dp_q;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Write data phase in progress
  always_ff @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in)
      wr_dp_q <= 1'b0;
    else
      wr_dp_q <= hsel_in && htrans_in[1] && hready_in && hwrite_in;
  property p_rd_wait;
    hsel_in && htrans_in[1] && hready_in && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_listen_only;
    passive_out |-> tx_pin_port_io_out && !rx_pin_port_io_out && !err_count_enable_out;
  endproperty
  a_listen_only: assert property (p_listen_only) else $error("listen-only pins");
  property p_listen_all;
    copy_on_error_out |-> accept_all_out && !passive_out;
  endproperty
  a_listen_all: assert property (p_listen_all) else $error("listen-all flags");
  property p_loopback;
    (err_count_enable_out && rx_pin_port_io_out) [*2] |-> engine_rx_out == $past(engine_tx_in);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback path");
  property p_capture;
    capture_event_out |-> $past(rx_done_in);
  endproperty
  a_capture: assert property (p_capture) else $error("capture without rx");
  property p_halt;
    module_halt_out |-> $past(cpu_idle_in);
  endproperty
  a_halt: assert property (p_halt) else $error("halt without idle");
  property p_abort;
    all_aborted_in && !wr_dp_q |-> ##2 !abort_all_tx_out;
  endproperty
  a_abort: assert property (p_abort) else $error("abort bit not cleared");
  property p_reset_cfg;
    $rose(reset_n_in) |-> err_count_clear_out && rx_pin_port_io_out;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("not config after reset");
  c_passive: cover property (passive_out);
  c_listen_all: cover property (copy_on_error_out);
  c_capture: cover property (capture_event_out);
endmodule : can_ctl_asserts

bind can_mode_and_buffer_control can_ctl_asserts i_can_ctl_asserts (.mclk_in, .reset_n_in,
  .hsel_in, .htrans_in, .hready_in, .hwrite_in, .hreadyout_out, .passive_out,
  .tx_pin_port_io_out, .rx_pin_port_io_out, .err_count_enable_out, .err_count_clear_out,
  .accept_all_out, .copy_on_error_out, .engine_rx_out, .engine_tx_in, .capture_event_out,
  .rx_done_in, .module_halt_out, .cpu_idle_in, .abort_all_tx_out, .all_aborted_in);

// File: can_bus_node.sv
// CAN bus partner: wired-AND of our transmit pin and one remote node.
// Assumes the remote node talks only while busy_in is high.
`timescale 1ns/100ps
module can_bus_node (
  input  wire logic mclk_in,
  input  wire logic busy_in,
  input  wire logic tx_pin_in,
  input  wire logic tx_oe_in,
  output logic      rx_pin_out
);
  logic [1:0] ph_q = 2'h0;
  always @(posedge mclk_in)
    ph_q <= ph_q + 2'h1;
  // Remote traffic never leaves 11 recessive bits; idle bus is recessive
  assign rx_pin_out = (busy_in ? ph_q[1] : 1'b1) & (tx_oe_in ? tx_pin_in : 1'b1);
endmodule : can_bus_node

// File: tb_top.sv
// Self-checking bench for the CAN mode and buffer control block.
// Assumes the bus partner model and the bound checker are compiled first.
`timescale 1ns/100ps
module tb_top;
  logic        mclk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0, hrdata, r;
  logic        hready, busy = 1'b0, fread = 1'b0, rx_pin, tx_pin, tx_oe;
  logic        etx = 1'b1, rx_done = 1'b0, aborted = 1'b0, idle = 1'b0, fill = 1'b0;
  logic [3:0]  hit = 4'h0, pend = 4'h0;
  logic [15:0] bufp = 16'h0;
  logic        capt, halt, abt, pas, acc, ptx, prx, errc, erx, window_select, onl, hresp;
  logic [2:0]  dma;
  logic [4:0]  fcnt, fst;
  int          n_fail = 0, check_count = 0, cyc = 0;

  can_mode_and_buffer_control #(.BIT_CYCLES(4)) i_can_mode_and_buffer_control (
    .mclk_in, .reset_n_in, .hsel_in(1'b1), .htrans_in(htrans), .haddr_in(haddr),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .can_rx_pin_in(rx_pin),
    .can_tx_pin_out(tx_pin), .can_tx_pin_oe_out(tx_oe), .tx_pin_port_io_out(ptx),
    .rx_pin_port_io_out(prx), .engine_tx_in(etx), .tx_busy_in(busy),
    .all_aborted_in(aborted), .rx_done_in(rx_done), .filter_hit_in(hit),
    .err_pend_in(pend[0]), .wake_pend_in(pend[1]), .rx_ovf_pend_in(pend[2]),
    .fifo_afull_pend_in(pend[3]), .buf_pend_in(bufp), .fifo_fill_in(fill),
    .fifo_read_in(fread), .cpu_idle_in(idle), .engine_rx_out(erx), .online_out(onl),
    .passive_out(pas), .err_count_enable_out(errc), .err_count_clear_out(),
    .accept_all_out(acc), .copy_on_error_out(), .abort_all_tx_out(abt),
    .module_halt_out(halt), .capture_event_out(capt), .window_select_out(window_select),
    .filter_data_bit_count_out(fcnt), .dma_buffer_count_out(dma), .fifo_start_buffer_out(fst));
  can_bus_node i_can_bus_node (.mclk_in, .busy_in(busy), .tx_pin_in(tx_pin),
    .tx_oe_in(tx_oe), .rx_pin_out(rx_pin));

  initial forever #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick
  task automatic wait_rdy;
    @(posedge mclk_in);
    while (hready !== 1'b1) @(posedge mclk_in);
  endtask : wait_rdy
  // Single AHB transfer: hold address phase, then data phase, until ready
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : bus
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, r, e);
  endtask : rc
  task automatic mode(input logic [2:0] m, input logic [7:0] e);
    bus(1'b1, 12'h000, 32'h2009 | (32'(m) << 8));
    repeat (60)
    begin
      bus(1'b0, 12'h000, 32'h0);
      if (r[7:5] === m) break;
    end
    chk("mode", r[7:5], m);
    chk("flags", {hresp, pas, acc, ptx, prx, errc, tx_oe, onl}, e);
  endtask : mode
  task automatic t_cfg;
    rc("mctl", 12'h000, 32'h0480);
    rc("unmap", 12'h014, 32'h0);
    bus(1'b1, 12'h000, 32'h2409);
    rc("mctl", 12'h000, 32'h2489);
    chk("win", window_select, 1'h1);
    bus(1'b1, 12'h004, 32'h11);
    bus(1'b1, 12'h004, 32'h12);
    rc("fcnt", 12'h004, 32'h11);
    chk("fcnt", fcnt, 5'h11);
    bus(1'b1, 12'h00C, 32'hE005);
    rc("fset", 12'h00C, 32'h0005);
    bus(1'b1, 12'h00C, 32'h2001);
    rc("fptr", 12'h010, 32'h0101);
    chk("dma", {dma, fst}, 8'h21);
    idle <= 1'b1;
    tick(2);
    chk("halt", halt, 1'h1);
    idle <= 1'b0;
    $display("done: config");
  endtask : t_cfg
  task automatic t_irq;
    rc("icode", 12'h008, 32'h40);
    bufp <= 16'h8400;
    for (int i = 0; i < 4; i++)
    begin
      pend <= 4'hF << i;
      rc("icode", 12'h008, 32'h41 + i);
    end
    pend <= 4'h0;
    hit <= 4'h9;
    rx_done <= 1'b1;
    tick(1);
    rx_done <= 1'b0;
    tick(1);
    chk("capt", capt, 1'h1);
    rc("icode", 12'h008, 32'h090A);
    $display("done: irq");
  endtask : t_irq
  task automatic t_modes;
    mode(3'h0, 8'h07);
    bus(1'b1, 12'h000, 32'h3009);
    tick(2);
    chk("abt", abt, 1'h1);
    aborted <= 1'b1;
    tick(1);
    aborted <= 1'b0;
    rc("abt", 12'h000, 32'h2009);
    busy <= 1'b1;
    fill <= 1'b1;
    tick(4);
    fill <= 1'b0;
    fread <= 1'b1;
    tick(1);
    fread <= 1'b0;
    rc("fptr", 12'h010, 32'h0502);
    fill <= 1'b1;
    tick(1);
    fill <= 1'b0;
    rc("wrap", 12'h010, 32'h0102);
    bus(1'b1, 12'h000, 32'h2209);
    tick(60);
    rc("busy", 12'h000, 32'h2209);
    busy <= 1'b0;
    mode(3'h2, 8'h1D);
    etx <= 1'b0;
    tick(2);
    chk("lpbk", {erx, tx_pin}, 2'h1);
    etx <= 1'b1;
    mode(3'h3, 8'h51);
    bus(1'b1, 12'h000, 32'h2509);
    rc("resv", 12'h000, 32'h2369);
    bus(1'b1, 12'h004, 32'h05);
    rc("lock", 12'h004, 32'h11);
    mode(3'h7, 8'h23);
    mode(3'h1, 8'h18);
    busy <= 1'b1;
    bus(1'b1, 12'h000, 32'h2409);
    rc("txbusy", 12'h000, 32'h2429);
    busy <= 1'b0;
    mode(3'h4, 8'h18);
    $display("done: modes");
  endtask : t_modes
  initial
  begin
    repeat (8) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    t_cfg();
    t_irq();
    t_modes();
    stop_test();
  end
endmodule : tb_top
